// ### inc/bst_pkg.sv
// Shared constants, states and carriers of the boundary-scan test port
package bst_pkg;

    // ==========================================================
    // Instruction register
    // ==========================================================
    localparam int         BST_IR_W       = 3;      // Instruction width
    localparam logic [2:0] BST_IR_EXTEST  = 3'h0;   // Drive chain on pins
    localparam logic [2:0] BST_IR_IDCODE  = 3'h1;   // Read identification
    localparam logic [2:0] BST_IR_SAMPLEZ = 3'h2;   // Sample, outputs hi-Z
    localparam logic [2:0] BST_IR_SAMPLE  = 3'h4;   // Sample / preload
    localparam logic [2:0] BST_IR_BYPASS  = 3'h7;   // One-bit pass-through
    localparam logic [2:0] BST_IR_CAPTURE = 3'h1;   // Pattern 01 in low bits

    // ==========================================================
    // Data registers
    // ==========================================================
    localparam int          BST_ID_W     = 32;           // Identification
    // Arbitrary neutral identification value; bit 0 set as required
    localparam logic [31:0] BST_ID_VALUE = 32'h0000_0001;
    localparam int          BST_BSR_W    = 16;           // Chain length
    // Chain positions with no pin behind them
    localparam logic [15:0] BST_BSR_PH   = 16'hc000;

    // ==========================================================
    // Controller states and register selection
    // ==========================================================
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } bst_state_e;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_BSR
    } bst_sel_e;

    // Controls handed to the memory core
    typedef struct packed {
        logic hiz;      // Force all memory outputs to high impedance
        logic extest;   // Memory outputs follow the chain update word
    } bst_ctl_s;

endpackage

// ### core/bst_tap.sv
// Boundary-scan test access port controller with its test registers
`timescale 1ns/1ps

// What this block does
// - Sample mode-select on test clock rise; float=1
// - Sample data input on test clock rise; float=1
// - Output changes on fall; drives only shifting
// - Five high mode-select rises reach reset state
// - Self reset at power-up; idle until clocked
// - Exactly one register selected between input/output
// - Registers shift on rise, present on fall
// - Three-bit instruction applies in idle, data states
// - Instruction loads only while it is selected
// - Reset state forces identification instruction
// - Bypass is a single one-bit register
// - Chain captures pins, then shifts them out
// - Pinless chain positions always capture one
// - Chain selected only by sample/extest instructions
// - Instruction capture loads 01 in low bits
// - New instruction takes effect at instruction update
// - 32-bit identification, bit 0 shifted first
// - High-impedance sample forces memory outputs off
module bst_tap
    import bst_pkg::*;
#(
    parameter int          BSR_W = BST_BSR_W,     // Chain length
    parameter logic [BSR_W-1:0] PH_MASK = BSR_W'(BST_BSR_PH)  // Pinless
) (
    input  wire logic             sys_clk_in,      // System clock
    input  wire logic             srst_in,         // Sync reset, high
    input  wire logic             tck_in,          // Test clock pin
    input  wire logic             tms_in,          // Mode-select pin
    input  wire logic             tdi_in,          // Serial data in
    input  wire logic [BSR_W-1:0] pins_data_in,    // Pin level word
    input  wire logic             pins_valid_in,   // Pin word valid
    output logic                  pins_ready_out,  // Buffer can take
    output logic                  tdo_out,         // Serial data out
    output logic                  tdo_oe_n_out,    // Low while driving
    output bst_ctl_s              ctl_out,         // Memory controls
    output logic [BSR_W-1:0]      bsr_upd_out      // Chain update word
);

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Controller next state from current state and mode-select
    function automatic bst_state_e next_of(bst_state_e s, logic m);
        bst_state_e n;
        n = s;
        case (s)
            ST_RESET:  n = m ? ST_RESET  : ST_IDLE;
            ST_IDLE:   n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  n = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  n = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  n = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  n = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
            default:   n = ST_RESET;
        endcase
        return n;
    endfunction

    // Data register chosen by an instruction; unused codes act as bypass
    function automatic bst_sel_e sel_of(logic [BST_IR_W-1:0] ir);
        bst_sel_e s;
        s = SEL_BYPASS;
        if (ir == BST_IR_IDCODE) begin
            s = SEL_ID;
        end else if (ir == BST_IR_SAMPLEZ || ir == BST_IR_SAMPLE ||
                     ir == BST_IR_EXTEST) begin
            s = SEL_BSR;
        end
        return s;
    endfunction

    // ==========================================================
    // Pin synchronisers and test clock edge detection
    // ==========================================================
    logic [1:0] tck_sync_r;     // Test clock, two stages
    logic [1:0] tms_sync_r;     // Mode-select, two stages
    logic [1:0] tdi_sync_r;     // Data input, two stages
    logic       tck_prev_r;     // Last synchronised clock level
    logic       tck_rise;       // Test clock rising edge seen
    logic       tck_fall;       // Test clock falling edge seen

    // All three pins share the same latency, so the sampled
    // mode-select and data line up with the detected clock edge
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tck_sync_r <= 2'h0;
            tms_sync_r <= 2'h3;
            tdi_sync_r <= 2'h3;
            tck_prev_r <= 1'b0;
        end else begin
            tck_sync_r <= {tck_sync_r[0], tck_in};
            tms_sync_r <= {tms_sync_r[0], tms_in};
            tdi_sync_r <= {tdi_sync_r[0], tdi_in};
            tck_prev_r <= tck_sync_r[1];
        end
    end

    assign tck_rise = tck_sync_r[1] & ~tck_prev_r;
    assign tck_fall = ~tck_sync_r[1] & tck_prev_r;

    // ==========================================================
    // Controller state machine
    // ==========================================================
    bst_state_e state_r;        // Current controller state
    bst_state_e state_nxt;      // State after this rising edge

    assign state_nxt = next_of(state_r, tms_sync_r[1]);

    // Power-up lands in reset and stays put while the clock is still
    // power-up self reset
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_r <= ST_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Instruction register
    // ==========================================================
    logic [BST_IR_W-1:0] ir_sh_r;   // Instruction shift stage
    logic [BST_IR_W-1:0] ir_r;      // Instruction in force
    bst_sel_e            sel;       // Data register now selected

    assign sel = sel_of(ir_r);

    // Shift stage: capture, shift, and reset preload
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ir_sh_r <= BST_IR_IDCODE;
        end else if (tck_rise) begin
            case (state_r)
                ST_RESET:  ir_sh_r <= BST_IR_IDCODE;
                ST_CAP_IR: ir_sh_r <= BST_IR_CAPTURE;
                ST_SH_IR:  ir_sh_r <= {tdi_sync_r[1],
                                       ir_sh_r[BST_IR_W-1:1]};
                default:   ir_sh_r <= ir_sh_r;
            endcase
        end
    end

    // Active instruction changes only at update or reset
    // three-bit instruction held
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ir_r <= BST_IR_IDCODE;
        end else if (tck_rise) begin
            if (state_nxt == ST_RESET) begin
                ir_r <= BST_IR_IDCODE;
            end else if (state_r == ST_UPD_IR) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    // ==========================================================
    // Pin sample buffer (two entries)
    // ==========================================================
    // Pin words queue here; capture pops one. With no capture the
    // buffer fills and ready drops, stalling the pin sampler.
    logic [BSR_W-1:0] buf_mem_r [2];    // Two queued pin words
    logic             buf_wp_r;         // Write index
    logic             buf_rp_r;         // Read index
    logic [1:0]       buf_cnt_r;        // Words held
    logic [1:0]       buf_cnt_nxt;      // Words held after this cycle
    logic [BSR_W-1:0] pins_last_r;      // Last word taken by capture
    logic [BSR_W-1:0] pins_now;         // Word used by a capture
    logic             buf_push;         // Word accepted from source
    logic             buf_pop;          // Word consumed by capture
    logic             bsr_capture;      // Chain capture this edge

    assign bsr_capture = tck_rise && state_r == ST_CAP_DR &&
                         sel == SEL_BSR;
    assign buf_push = pins_valid_in & pins_ready_out;
    assign buf_pop  = bsr_capture && buf_cnt_r != 2'h0;
    assign pins_now = (buf_cnt_r != 2'h0) ? buf_mem_r[buf_rp_r]
                                          : pins_last_r;

    // Fill level for the next cycle
    always_comb begin
        buf_cnt_nxt = buf_cnt_r;
        if (buf_push && !buf_pop) begin
            buf_cnt_nxt = buf_cnt_r + 2'h1;
        end else if (buf_pop && !buf_push) begin
            buf_cnt_nxt = buf_cnt_r - 2'h1;
        end
    end

    // Pointers, level and registered ready
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            buf_wp_r       <= 1'b0;
            buf_rp_r       <= 1'b0;
            buf_cnt_r      <= 2'h0;
            pins_ready_out <= 1'b0;
        end else begin
            buf_wp_r       <= buf_wp_r ^ buf_push;
            buf_rp_r       <= buf_rp_r ^ buf_pop;
            buf_cnt_r      <= buf_cnt_nxt;
            pins_ready_out <= buf_cnt_nxt != 2'h2;
        end
    end

    // Storage and the last captured word
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            buf_mem_r[0] <= '0;
            buf_mem_r[1] <= '0;
            pins_last_r  <= '0;
        end else begin
            if (buf_push) begin
                buf_mem_r[buf_wp_r] <= pins_data_in;
            end
            if (buf_pop) begin
                pins_last_r <= buf_mem_r[buf_rp_r];
            end
        end
    end

    // ==========================================================
    // Data registers
    // ==========================================================
    logic                byp_r;    // Bypass bit
    logic [BST_ID_W-1:0] id_r;     // Identification shift register
    logic [BSR_W-1:0]    bsr_r;    // Boundary scan chain

    // Capture and shift on rising edges; only the selected one moves
    // one register at a time
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            byp_r <= 1'b0;
            id_r  <= BST_ID_VALUE;
            bsr_r <= '0;
        end else if (tck_rise) begin
            if (state_r == ST_CAP_DR) begin
                case (sel)
                    SEL_BYPASS: byp_r <= 1'b0;
                    SEL_ID:     id_r  <= BST_ID_VALUE;
                    default:    bsr_r <= pins_now | PH_MASK;
                endcase
            end else if (state_r == ST_SH_DR) begin
                case (sel)
                    SEL_BYPASS: byp_r <= tdi_sync_r[1];
                    SEL_ID:     id_r  <= {tdi_sync_r[1], id_r[BST_ID_W-1:1]};
                    default:    bsr_r <= {tdi_sync_r[1],
                                          bsr_r[BSR_W-1:1]};
                endcase
            end
        end
    end

    // ==========================================================
    // Serial output on falling edges
    // ==========================================================
    logic tdo_bit;      // Low bit of whichever register is in path

    always_comb begin
        tdo_bit = byp_r;
        if (state_r == ST_SH_IR) begin
            tdo_bit = ir_sh_r[0];
        end else if (state_r != ST_SH_DR) begin
            tdo_bit = 1'b1;     // Rests high so an idle pin reads one
        end else if (sel == SEL_ID) begin
            tdo_bit = id_r[0];
        end else if (sel == SEL_BSR) begin
            tdo_bit = bsr_r[0];
        end
    end

    // Level and enable move only at a falling test clock edge
    // falling edge, shift states only
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tdo_out      <= 1'b1;
            tdo_oe_n_out <= 1'b1;
        end else if (tck_fall) begin
            tdo_out      <= tdo_bit;
            tdo_oe_n_out <= !(state_r == ST_SH_IR ||
                              state_r == ST_SH_DR);
        end
    end

    // ==========================================================
    // Memory-side controls
    // ==========================================================
    // Update word latched at data update so pins see a stable value
    // while the chain keeps shifting
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ctl_out     <= '0;
            bsr_upd_out <= '0;
        end else begin
            ctl_out.hiz    <= ir_r == BST_IR_SAMPLEZ;
            ctl_out.extest <= ir_r == BST_IR_EXTEST;
            if (tck_rise && state_r == ST_UPD_DR && sel == SEL_BSR) begin
                bsr_upd_out <= bsr_r;
            end
        end
    end

endmodule

// ### verif/bst_tap_checker.sv
// Port-level checks of the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_checker
    import bst_pkg::*;
#(
    parameter int BSR_W = BST_BSR_W  // Chain length
) (
    input wire logic             sys_clk_in,
    input wire logic             srst_in,
    input wire logic             tck_in,
    input wire logic             tms_in,
    input wire logic             tdi_in,
    input wire logic [BSR_W-1:0] pins_data_in,
    input wire logic             pins_valid_in,
    input wire logic             pins_ready_out,
    input wire logic             tdo_out,
    input wire logic             tdo_oe_n_out,
    input wire bst_ctl_s         ctl_out,
    input wire logic [BSR_W-1:0] bsr_upd_out
);
    // ==========================================================
    // Test clock pin edge ages, counted in sys clocks
    // ==========================================================
    logic       tck_q_r;                     // Pin, one clock late
    logic [2:0] rise_r;                      // Since rise, stops at 7
    logic [2:0] fall_r;                      // Since fall, stops at 7
    logic [2:0] ones_r;                      // Rises with mode high
    wire        rise_w = tck_in & ~tck_q_r;  // Pin rise found
    wire        fall_w = ~tck_in & tck_q_r;  // Pin fall found

    // Ages saturate so a stale edge never looks recent
    always_ff @(posedge sys_clk_in) begin
        tck_q_r <= srst_in ? 1'b0 : tck_in;
        rise_r  <= (srst_in | rise_w) ? {~rise_w, 2'h3} & 3'h7 :
                   rise_r + 3'(rise_r != 3'h7);
        fall_r  <= (srst_in | fall_w) ? {~fall_w, 2'h3} & 3'h7 :
                   fall_r + 3'(fall_r != 3'h7);
        if (srst_in) ones_r <= 3'h0;
        else if (rise_w) ones_r <= tms_in ? ones_r + 3'(ones_r != 3'h7) : 3'h0;
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_reset_quiet: assert property (
        $fell(srst_in) |-> tdo_oe_n_out && tdo_out && ctl_out == 2'h0)
        else $error("Port not idle after reset");
    a_ready_release: assert property (
        $fell(srst_in) |-> ##[1:2] pins_ready_out)
        else $error("Buffer not ready after reset");
    a_tdo_on_fall: assert property (
        $changed({tdo_out, tdo_oe_n_out}) && !$past(srst_in)
        |-> fall_r inside {[3'h1:3'h6]})
        else $error("Serial output moved away from a clock fall");
    a_tdo_idle_one: assert property (
        tdo_oe_n_out |-> tdo_out)
        else $error("Serial output not idle high");
    a_ctl_on_rise: assert property (
        $changed(ctl_out) && !$past(srst_in) |-> rise_r inside {[3'h1:3'h6]})
        else $error("Controls moved away from a clock rise");
    a_upd_on_rise: assert property (
        $changed(bsr_upd_out) && !$past(srst_in)
        |-> rise_r inside {[3'h1:3'h6]})
        else $error("Update word moved away from a clock rise");
    a_ctl_exclusive: assert property (
        !(ctl_out.hiz && ctl_out.extest))
        else $error("Two instructions active at once");
    a_five_ones: assert property (
        ones_r == 3'h5 && $past(ones_r) == 3'h4 |-> ##[1:8] ctl_out == 2'h0)
        else $error("Five high mode rises did not reset");
    a_buf_full: assert property (
        pins_valid_in && pins_ready_out ##1 pins_valid_in && pins_ready_out
        |=> !pins_ready_out)
        else $error("Buffer took a third word");

    c_shifting: cover property (!tdo_oe_n_out);
    c_buf_full: cover property (!pins_ready_out);
    c_hiz:      cover property (ctl_out.hiz);
endmodule

// ### verif/bst_ctrl_model.sv
// Behavioural test controller driving the serial test port
`timescale 1ns/1ps
module bst_ctrl_model (
    input  wire logic sys_clk_in,   // Bench time base
    input  wire logic tdo_in,       // Serial data from the port
    input  wire logic tdo_oe_n_in,  // Low while the port drives
    output logic      tck_out,      // Test clock, rests low
    output logic      tms_out,      // Mode-select line
    output logic      tdi_out       // Serial data line
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // One test clock period of 40 sys clocks; a floating output reads X
    task automatic tbit(input logic tms, input logic tdi, output logic tdo);
        @(negedge sys_clk_in);
        tms_out = tms;
        tdi_out = tdi;
        repeat (12) @(negedge sys_clk_in);
        tdo = tdo_oe_n_in ? 1'bx : tdo_in;
        tck_out = 1'b1;
        repeat (20) @(negedge sys_clk_in);
        tck_out = 1'b0;
        repeat (7) @(negedge sys_clk_in);
        // hold time over, lines let go
        tms_out = 1'b1;
        tdi_out = 1'b1;
    endtask
endmodule

// ### verif/test_bst_tap.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
module test_bst_tap
    import bst_pkg::*;
;
    localparam int LIMIT = 30000;         // Cycle ceiling for a hang
    logic        sys_clk_in    = 1'b0;
    logic        srst_in       = 1'b1;
    logic [15:0] pins_data_in  = 16'h0;
    logic        pins_valid_in = 1'b0;
    logic        tck, tms, tdi, tdo, tdo_oe_n, pins_ready_out;
    bst_ctl_s    ctl_out;
    logic [15:0] bsr_upd_out;
    int          failures        = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    logic [31:0] d;

    always #2 sys_clk_in = ~sys_clk_in;

    bst_tap #(.BSR_W(16)) i_dut (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .pins_data_in(pins_data_in),
        .pins_valid_in(pins_valid_in), .pins_ready_out(pins_ready_out),
        .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .ctl_out(ctl_out),
        .bsr_upd_out(bsr_upd_out));
    bst_ctrl_model i_ctrl (
        .sys_clk_in(sys_clk_in), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n),
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    // From idle: capture, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        dout = '0;
        i_ctrl.tbit(1'b1, 1'b1, t);
        if (ir) i_ctrl.tbit(1'b1, 1'b1, t);
        i_ctrl.tbit(1'b0, 1'b1, t);
        i_ctrl.tbit(1'b0, 1'b1, t);
        for (int i = 0; i < n; i++) begin
            i_ctrl.tbit(i == n - 1, din[i], t);
            dout[i] = t;
        end
        i_ctrl.tbit(1'b1, 1'b1, t);
        i_ctrl.tbit(1'b0, 1'b1, t);
    endtask

    // Offer a pin word and hold it until the buffer takes it
    task automatic push(input logic [15:0] w);
        @(negedge sys_clk_in);
        pins_data_in  = w;
        pins_valid_in = 1'b1;
        do @(posedge sys_clk_in); while (pins_ready_out !== 1'b1);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_idcode();
        logic t;
        check(32'(ctl_out), 32'h0, "controls at power-up");
        i_ctrl.tbit(1'b0, 1'b1, t);
        check(32'(tdo_oe_n), 32'h1, "output idle");
        scan(1'b0, 32, 32'h0, d);
        check(d, BST_ID_VALUE, "id word");
        $display("idcode test done");
    endtask

    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            scan(1'b1, 3, 32'(codes[i]), d);
            check(d, 32'(BST_IR_CAPTURE), "ir capture");
            scan(1'b0, 2, 32'h1, d);
            check(d, 32'h2, "bypass path");
        end
        $display("bypass test done");
    endtask

    // Two words fill the buffer and stall a third; captures then drain it
    task automatic t_sample();
        push(16'h1234);
        push(16'h00ff);
        @(negedge sys_clk_in);
        pins_valid_in = 1'b0;
        @(negedge sys_clk_in);
        pins_data_in  = 16'hbeef;
        pins_valid_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        check(32'(pins_ready_out), 32'h0, "full buffer ready");
        pins_valid_in = 1'b0;
        scan(1'b1, 3, 32'(BST_IR_SAMPLE), d);
        scan(1'b0, 16, 32'h0, d);
        check(d, 32'h1234 | 32'(BST_BSR_PH), "chain word a");
        check(32'(pins_ready_out), 32'h1, "ready after pop");
        scan(1'b0, 16, 32'h0, d);
        check(d, 32'h00ff | 32'(BST_BSR_PH), "chain word b");
        check(32'(ctl_out), 32'h0, "sample controls");
        $display("sample test done");
    endtask

    task automatic t_samplez();
        scan(1'b1, 3, 32'(BST_IR_SAMPLEZ), d);
        check(32'(ctl_out), 32'h2, "hiz control");
        scan(1'b0, 16, 32'h0, d);
        check(d, 32'h00ff | 32'(BST_BSR_PH), "empty buffer word");
        $display("samplez test done");
    endtask

    task automatic t_extest();
        scan(1'b1, 3, 32'(BST_IR_EXTEST), d);
        check(32'(ctl_out), 32'h1, "extest control");
        scan(1'b0, 16, 32'h5a3c, d);
        check(d, 32'h00ff | 32'(BST_BSR_PH), "extest capture");
        check(32'(bsr_upd_out), 32'h5a3c, "update word");
        $display("extest test done");
    endtask

    // Abandon a data shift with five high mode-select rises
    task automatic t_tms_reset();
        logic t;
        i_ctrl.tbit(1'b1, 1'b1, t);
        i_ctrl.tbit(1'b0, 1'b1, t);
        i_ctrl.tbit(1'b0, 1'b1, t);
        repeat (5) i_ctrl.tbit(1'b1, 1'b1, t);
        check(32'(ctl_out), 32'h0, "controls after reset");
        check(32'(tdo_oe_n), 32'h1, "output released");
        i_ctrl.tbit(1'b0, 1'b1, t);
        scan(1'b0, 32, 32'h0, d);
        check(d, BST_ID_VALUE, "id after reset");
        $display("tms reset test done");
    endtask

    // Mid-run reset drops an active instruction back to identification
    task automatic t_reset();
        logic t;
        scan(1'b1, 3, 32'(BST_IR_SAMPLEZ), d);
        check(32'(ctl_out), 32'h2, "hiz before reset");
        @(negedge sys_clk_in);
        srst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        srst_in = 1'b0;
        check(32'(ctl_out), 32'h0, "controls after srst");
        i_ctrl.tbit(1'b0, 1'b1, t);
        scan(1'b0, 32, 32'h0, d);
        check(d, BST_ID_VALUE, "id after srst");
        $display("mid-run reset test done");
    endtask

    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    initial begin
        repeat (8) @(negedge sys_clk_in);
        srst_in = 1'b0;
        t_idcode();
        t_bypass();
        t_sample();
        t_samplez();
        t_extest();
        t_tms_reset();
        t_reset();
        end_of_test();
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("Error at %0t: run hung", $time);
            end_of_test();
        end
    end
endmodule

bind bst_tap bst_tap_checker #(.BSR_W(BSR_W)) i_chk (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .tck_in(tck_in),
    .tms_in(tms_in), .tdi_in(tdi_in), .pins_data_in(pins_data_in),
    .pins_valid_in(pins_valid_in), .pins_ready_out(pins_ready_out),
    .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .ctl_out(ctl_out),
    .bsr_upd_out(bsr_upd_out));
